/* File: bench/testbench.sv */
// Self-checking bench of the indexed watchdog timer.
module testbench import wdt_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] CPM = 16'h0004; // Short millisecond keeps the run brief
	localparam logic [7:0] UNITS [4] = '{8'h10, 8'h10, 8'h18, 8'h00}; // Unit codes
	localparam int MSS [4] = '{1, 1, 60, 1000}; // Milliseconds per step
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	wdt_io_req_s io_req = '0;
	logic [7:0] io_rdata;
	logic kbd_act = 1'b0;
	logic mouse_act = 1'b0;
	logic timeout_pulse;
	logic timeout_sts;
	int fail_count = 0;
	int n_tests = 0;
	// Clock generator
	always #20 clk_sys = ~clk_sys;
	wdt_top #(.CYC_PER_MS(CPM)) i_wdt_top (.clk_sys(clk_sys), .rst_n(rst_n), .io_req(io_req),
		.io_rdata(io_rdata), .kbd_act(kbd_act), .mouse_act(mouse_act),
		.timeout_pulse(timeout_pulse), .timeout_sts(timeout_sts));
	// Compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	// One host cycle, strobe held a single edge
	task automatic io(input logic rd, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		io_req <= '{wr: !rd, rd: rd, addr: a, wdata: d};
		@(posedge clk_sys);
		io_req <= '0;
		#1;
	endtask : io
	task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
		io(1'b0, WDT_INDEX_PORT, idx);
		io(1'b0, WDT_DATA_PORT, v);
	endtask : wreg
	task automatic rreg(input logic [7:0] idx, input logic [7:0] exp, input string what);
		io(1'b0, WDT_INDEX_PORT, idx);
		io(1'b1, WDT_DATA_PORT, 8'h00);
		check(io_rdata, exp, what);
	endtask : rreg
	// Cycles until the timeout pulse, bounded
	task automatic wait_pulse(input int lim, output int n);
		n = 0;
		while (timeout_pulse !== 1'b1 && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
	endtask : wait_pulse
	function automatic logic in_win(input int n, input int e);
		return n >= e - 1 && n <= e + 4;
	endfunction : in_win
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	// Hang guard, several times the expected span yet inside the cycle budget
	initial begin
		#(60000 * 40);
		fail_count++;
		print_verdict();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin : main
		int n;
		int c;
		logic hit;
		c = $urandom(69);
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		check(io_rdata, WDT_IDLE_READ, "reset read data");
		check({6'h00, timeout_pulse, timeout_sts}, 8'h00, "reset outputs");
		// Aborted key pair keeps the port closed
		io(1'b0, WDT_INDEX_PORT, WDT_KEY_UNLOCK);
		io(1'b0, WDT_DATA_PORT, 8'h00);
		io(1'b0, WDT_INDEX_PORT, WDT_KEY_UNLOCK);
		// Index read: an open port would answer index 00 here
		io(1'b1, WDT_INDEX_PORT, 8'h00);
		check(io_rdata, WDT_IDLE_READ, "locked read");
		io(1'b0, WDT_INDEX_PORT, WDT_KEY_UNLOCK);
		rreg(WDT_IDX_ACT, WDT_IDLE_READ, "bank gate");
		wreg(WDT_IDX_BANK, WDT_BANK_WDT);
		// Index location reads back the selected index while open
		io(1'b0, WDT_INDEX_PORT, WDT_IDX_UNIT);
		io(1'b1, WDT_INDEX_PORT, 8'h00);
		check(io_rdata, WDT_IDX_UNIT, "index read");
		rreg(WDT_IDX_ACT, WDT_RST_ACT, "activation reset");
		rreg(WDT_IDX_UNIT, WDT_RST_UNIT, "unit reset");
		rreg(WDT_IDX_CNT, WDT_RST_CNT, "count reset");
		rreg(WDT_IDX_CTL, 8'h00, "control reset");
		wreg(WDT_IDX_ACT, 8'h01);
		// Expiry in every unit but whole minutes, boundary and random counts
		for (int i = 0; i < 4; i++) begin
			c = (i == 0) ? 255 : (i == 1) ? ($urandom % 255) + 1 : 1;
			wreg(WDT_IDX_UNIT, UNITS[i]);
			wreg(WDT_IDX_CNT, 8'(c));
			wait_pulse(8000, n);
			check(8'(in_win(n, MSS[i] * c * CPM)), 8'h01, "expiry time");
			rreg(WDT_IDX_CTL, 8'h10, "timeout status");
			rreg(WDT_IDX_CNT, 8'h00, "stopped count");
		end
		// Zero count stops and clears status
		wreg(WDT_IDX_CNT, 8'h00);
		@(posedge clk_sys);
		#1;
		check(8'(timeout_sts), 8'h00, "status clear");
		wait_pulse(400, n);
		check(8'(n), 8'(400), "zero stops");
		// Whole minutes: no expiry where a second step would have ended
		wreg(WDT_IDX_UNIT, 8'h08);
		rreg(WDT_IDX_UNIT, 8'h08, "minute unit readback");
		wreg(WDT_IDX_CNT, 8'h01);
		wait_pulse(1000 * CPM + 100, n);
		check(8'(n == 1000 * CPM + 100), 8'h01, "minute unit");
		// Rewrite mid-count restarts from the new value
		wreg(WDT_IDX_UNIT, 8'h10);
		wreg(WDT_IDX_CNT, 8'h05);
		repeat (12) @(posedge clk_sys);
		wreg(WDT_IDX_CNT, 8'h05);
		wait_pulse(100, n);
		check(8'(in_win(n, 5 * CPM)), 8'h01, "reload restart");
		// Keyboard then mouse, disabled then enabled
		for (int j = 0; j < 2; j++) begin
			for (int en = 0; en < 2; en++) begin
				wreg(WDT_IDX_CTL, en ? (j ? 8'h80 : 8'h40) : 8'h00);
				wreg(WDT_IDX_CNT, 8'h04);
				hit = 1'b0;
				for (int k = 0; k < 48; k++) begin
					@(posedge clk_sys);
					if (j) mouse_act <= (k % 8) < 2;
					else kbd_act <= (k % 8) < 2;
					#1;
					hit |= timeout_pulse;
				end
				check(8'(hit), 8'(en == 0), "activity reload");
				wait_pulse(100, n);
				check(8'(n < 100), 8'(en), "expiry after activity");
			end
		end
		// Forced timeout clears itself
		wreg(WDT_IDX_CTL, 8'h00);
		wreg(WDT_IDX_CNT, 8'h00);
		wreg(WDT_IDX_CTL, 8'h20);
		// Pulse stands only in the cycle right after the write edge
		check(8'(timeout_pulse), 8'h01, "forced pulse");
		rreg(WDT_IDX_CTL, 8'h10, "force self clear");
		// Lock closes the port again
		io(1'b0, WDT_INDEX_PORT, WDT_KEY_LOCK);
		io(1'b1, WDT_DATA_PORT, 8'h00);
		check(io_rdata, WDT_IDLE_READ, "relocked read");
		print_verdict();
	end
endmodule : testbench

/* File: bench/wdt_top_asserts.sv */
// Checker of the watchdog's host port and timeout outputs.
module wdt_top_asserts
	import wdt_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire wdt_pkg::wdt_io_req_s io_req,
	input wire logic [7:0] io_rdata,
	input wire logic timeout_pulse,
	input wire logic timeout_sts
);
	// ----------------------------------------------------------------
	// Shadow of lock state, index and bank
	// ----------------------------------------------------------------
	typedef struct packed {
		logic key1; // First key seen
		logic open; // Configuration open
		logic [7:0] idx; // Last index written while open
		logic [7:0] bank; // Selected bank
	} wdt_chk_s;
	wdt_chk_s st_q, st_d;
	logic wr_idx, wr_dat, frc_wr, cnt_wr, rd_port;
	assign wr_idx = io_req.wr && io_req.addr == WDT_INDEX_PORT;
	assign wr_dat = io_req.wr && io_req.addr == WDT_DATA_PORT;
	assign rd_port = io_req.rd && (io_req.addr == WDT_INDEX_PORT || io_req.addr == WDT_DATA_PORT);
	// Data writes that reach the watchdog bank
	assign cnt_wr = wr_dat && st_q.open && st_q.bank == WDT_BANK_WDT && st_q.idx == WDT_IDX_CNT;
	assign frc_wr = wr_dat && st_q.open && st_q.bank == WDT_BANK_WDT && st_q.idx == WDT_IDX_CTL
		&& io_req.wdata[WDT_CTL_FORCE_BIT];
	// Any port write between the keys aborts the unlock
	always_comb begin
		st_d = st_q;
		if (!st_q.open && (wr_idx || wr_dat)) begin
			st_d.key1 = wr_idx && io_req.wdata == WDT_KEY_UNLOCK && !st_q.key1;
			st_d.open = wr_idx && io_req.wdata == WDT_KEY_UNLOCK && st_q.key1;
		end else if (st_q.open && wr_idx) begin
			st_d.open = io_req.wdata != WDT_KEY_LOCK;
			if (io_req.wdata != WDT_KEY_LOCK) begin
				st_d.idx = io_req.wdata; // Lock key leaves the index alone
			end
		end else if (st_q.open && wr_dat && st_q.idx == WDT_IDX_BANK) begin
			st_d.bank = io_req.wdata;
		end
	end
	// Shadow register
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Forced timeout: a single pulse right after the write
	sequence s_one_pulse;
		timeout_pulse ##1 !timeout_pulse;
	endsequence
	force_pulse_a: assert property (frc_wr |=> s_one_pulse)
		else $error("forced timeout did not pulse once");
	pulse_one_a: assert property (timeout_pulse |=> !timeout_pulse)
		else $error("timeout pulse longer than one cycle");
	pulse_sts_a: assert property (timeout_pulse |-> timeout_sts)
		else $error("pulse without status");
	sts_cause_a: assert property ($rose(timeout_sts) |-> timeout_pulse)
		else $error("status rose without timeout");
	sts_hold_a: assert property (timeout_sts && !cnt_wr |=> timeout_sts)
		else $error("status dropped without count write");
	sts_clear_a: assert property (cnt_wr |=> !timeout_sts)
		else $error("count write left status set");
	locked_read_a: assert property (rd_port && !st_q.open |=> io_rdata == WDT_IDLE_READ)
		else $error("locked read not idle value");
	index_read_a: assert property (io_req.rd && st_q.open && io_req.addr == WDT_INDEX_PORT
		|=> io_rdata == $past(st_q.idx))
		else $error("index read mismatch");
	bank_gate_a: assert property (io_req.rd && io_req.addr == WDT_DATA_PORT && st_q.open
		&& st_q.bank != WDT_BANK_WDT && st_q.idx != WDT_IDX_BANK
		|=> io_rdata == WDT_IDLE_READ)
		else $error("other bank answered");
	rdata_hold_a: assert property (!io_req.rd |=> $stable(io_rdata))
		else $error("read data moved without read");
endmodule : wdt_top_asserts

bind wdt_top wdt_top_asserts i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .io_req(io_req),
	.io_rdata(io_rdata), .timeout_pulse(timeout_pulse), .timeout_sts(timeout_sts));

/* File: verilog/wdt_div.sv */
// Tick divider: one output tick per div input ticks.
module wdt_div #(
	parameter int W = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic restart,
	input wire logic tick_in,
	input wire logic [W-1:0] div,
	output logic tick_out
);
	import wdt_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] cnt; // Input ticks seen in this period
		logic tick; // Output tick
	} wdt_div_s;

	wdt_div_s q; // Registered state
	wdt_div_s d; // Next state

	// Count input ticks, restart wipes a partial period
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (restart) begin
			d.cnt = '0;
		end else if (tick_in) begin
			if (q.cnt >= div - 1'b1) begin
				// Period complete
				d.cnt = '0;
				d.tick = 1'b1;
			end else begin
				d.cnt = q.cnt + 1'b1;
			end
		end
	end

	// Register the state
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick_out = q.tick;

endmodule : wdt_div

/* File: verilog/wdt_pkg.sv */
// Shared constants and carrier types of the indexed watchdog timer.
package wdt_pkg;

	// ----------------------------------------------------------------
	// Host I/O locations and access keys
	// ----------------------------------------------------------------
	localparam logic [15:0] WDT_INDEX_PORT = 16'h002E; // Index location
	localparam logic [15:0] WDT_DATA_PORT = 16'h002F; // Data location
	localparam logic [7:0] WDT_KEY_UNLOCK = 8'h87; // Written twice to open
	localparam logic [7:0] WDT_KEY_LOCK = 8'hAA; // Closes configuration
	localparam logic [7:0] WDT_IDLE_READ = 8'hFF; // Read value while closed

	// ----------------------------------------------------------------
	// Register indices and values
	// ----------------------------------------------------------------
	localparam logic [7:0] WDT_IDX_BANK = 8'h07; // bank_select
	localparam logic [7:0] WDT_IDX_ACT = 8'h30; // function_activate
	localparam logic [7:0] WDT_IDX_UNIT = 8'hF5; // count_unit_config
	localparam logic [7:0] WDT_IDX_CNT = 8'hF6; // timeout_count
	localparam logic [7:0] WDT_IDX_CTL = 8'hF7; // watchdog_control_status
	localparam logic [7:0] WDT_BANK_WDT = 8'h08; // Bank holding the watchdog

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int WDT_ACT_EN_BIT = 0; // Activation enable
	localparam int WDT_UNIT_MIN_BIT = 3; // 1 = minutes, 0 = seconds
	localparam int WDT_UNIT_FAST_BIT = 4; // 1 = thousand times faster
	localparam int WDT_CTL_STS_BIT = 4; // Timeout status
	localparam int WDT_CTL_FORCE_BIT = 5; // Forced timeout, self clearing
	localparam int WDT_CTL_KBD_BIT = 6; // Keyboard reload enable
	localparam int WDT_CTL_MS_BIT = 7; // Mouse reload enable

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] WDT_RST_BANK = 8'h00;
	localparam logic [7:0] WDT_RST_ACT = 8'h00;
	localparam logic [7:0] WDT_RST_UNIT = 8'h00;
	localparam logic [7:0] WDT_RST_CNT = 8'h00;
	localparam logic [7:0] WDT_RST_IDX = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned WDT_CLK_PERIOD_NS = 40; // 25 MHz system clock
	localparam int unsigned WDT_MS_NS = 1000000; // One millisecond in ns
	localparam int unsigned WDT_MS_CYCLES = WDT_MS_NS / WDT_CLK_PERIOD_NS;
	localparam logic [15:0] WDT_MS_PER_SEC = 16'd1000; // Milliseconds per second
	localparam logic [15:0] WDT_MS_PER_MIN = 16'd60000; // Milliseconds per minute
	localparam logic [15:0] WDT_MS_PER_FMIN = 16'd60; // Thousandth minute in ms
	localparam logic [15:0] WDT_MS_PER_FSEC = 16'd1; // Thousandth second in ms

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		WDT_LOCKED = 2'b00, // Configuration closed
		WDT_KEY1 = 2'b01, // First key seen
		WDT_OPEN = 2'b11 // Configuration open
	} wdt_lock_e;

	// Host I/O cycle, one strobe per access
	typedef struct packed {
		logic wr; // Write strobe
		logic rd; // Read strobe
		logic [15:0] addr; // I/O address
		logic [7:0] wdata; // Write data
	} wdt_io_req_s;

endpackage : wdt_pkg

/* File: verilog/wdt_top.sv */
// Indexed watchdog timer with key-protected configuration space.
module wdt_top #(
	parameter logic [15:0] CYC_PER_MS = 16'(wdt_pkg::WDT_MS_CYCLES) // Shorten in simulation
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire wdt_pkg::wdt_io_req_s io_req,
	output logic [7:0] io_rdata,
	input wire logic kbd_act,
	input wire logic mouse_act,
	output logic timeout_pulse,
	output logic timeout_sts
);
	import wdt_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		wdt_lock_e st; // Unlock sequence state
		logic [7:0] idx; // Selected register index
		logic [7:0] bank; // Selected bank
		logic [7:0] act; // Activation register
		logic [7:0] unit; // Unit configuration
		logic [7:0] cnt; // Live count
		logic [7:0] reload; // Last written count
		logic kbd_en; // Keyboard reload enable
		logic ms_en; // Mouse reload enable
		logic sts; // Timeout status
		logic tmo; // Timeout pulse
		logic [7:0] rdata; // Read data
		logic [2:0] kbd_sync; // Keyboard pin synchroniser
		logic [2:0] ms_sync; // Mouse pin synchroniser
		logic kbd_lvl; // Accepted keyboard level
		logic ms_lvl; // Accepted mouse level
	} wdt_state_s;

	wdt_state_s q; // Registered state
	wdt_state_s d; // Next state

	logic ms_tick; // One millisecond tick
	logic unit_tick; // One count step
	logic restart; // Wipe partial prescaler periods
	logic [15:0] unit_div; // Milliseconds per count step

	// ----------------------------------------------------------------
	// Decode of the host cycle
	// ----------------------------------------------------------------
	logic wr_idx; // Write to index location
	logic wr_dat; // Write to data location
	logic rd_idx; // Read of index location
	logic rd_dat; // Read of data location
	logic open; // Configuration unlocked
	logic wdt_sel; // Watchdog bank selected
	logic cnt_wr; // Count register written
	logic run; // Counter running
	logic kbd_ev; // Accepted keyboard rising edge
	logic ms_ev; // Accepted mouse rising edge

	assign wr_idx = io_req.wr && io_req.addr == WDT_INDEX_PORT;
	assign wr_dat = io_req.wr && io_req.addr == WDT_DATA_PORT;
	assign rd_idx = io_req.rd && io_req.addr == WDT_INDEX_PORT;
	assign rd_dat = io_req.rd && io_req.addr == WDT_DATA_PORT;
	assign open = q.st == WDT_OPEN;
	assign wdt_sel = q.bank == WDT_BANK_WDT;
	assign cnt_wr = open && wr_dat && wdt_sel && q.idx == WDT_IDX_CNT;
	assign run = q.act[WDT_ACT_EN_BIT] && q.cnt != 8'h00;

	// Edges count only once second and third stages agree
	assign kbd_ev = q.kbd_sync[2] == q.kbd_sync[1] && q.kbd_sync[1] && !q.kbd_lvl;
	assign ms_ev = q.ms_sync[2] == q.ms_sync[1] && q.ms_sync[1] && !q.ms_lvl;

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------
	// Fast mode keeps the ms tick and shrinks the step to a thousandth unit
	always_comb begin
		unit_div = WDT_MS_PER_SEC;
		unique case ({q.unit[WDT_UNIT_FAST_BIT], q.unit[WDT_UNIT_MIN_BIT]})
			2'b00: unit_div = WDT_MS_PER_SEC;
			2'b01: unit_div = WDT_MS_PER_MIN;
			2'b10: unit_div = WDT_MS_PER_FSEC;
			2'b11: unit_div = WDT_MS_PER_FMIN;
		endcase
	end

	// Any reload starts a full fresh step, not a leftover fraction
	assign restart = cnt_wr || (run && ((kbd_ev && q.kbd_en) || (ms_ev && q.ms_en)));

	// Clock cycles to milliseconds
	wdt_div #(
		.W(16)
	) u_ms_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.restart(restart),
		.tick_in(1'b1),
		.div(CYC_PER_MS),
		.tick_out(ms_tick)
	);

	// Milliseconds to count steps
	wdt_div #(
		.W(16)
	) u_unit_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.restart(restart),
		.tick_in(ms_tick),
		.div(unit_div),
		.tick_out(unit_tick)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.tmo = 1'b0;

		// Pin synchronisers, first stage feeds only the second
		d.kbd_sync = {q.kbd_sync[1:0], kbd_act};
		d.ms_sync = {q.ms_sync[1:0], mouse_act};
		if (q.kbd_sync[2] == q.kbd_sync[1]) begin
			d.kbd_lvl = q.kbd_sync[1];
		end
		if (q.ms_sync[2] == q.ms_sync[1]) begin
			d.ms_lvl = q.ms_sync[1];
		end

		// Unlock sequence; nothing else is honoured while closed
		unique case (q.st)
			WDT_LOCKED: begin
				if (wr_idx && io_req.wdata == WDT_KEY_UNLOCK) begin
					d.st = WDT_KEY1;
				end
			end
			WDT_KEY1: begin
				if (wr_idx && io_req.wdata == WDT_KEY_UNLOCK) begin
					d.st = WDT_OPEN;
				end else if (wr_idx || wr_dat) begin
					// Keys must be back to back
					d.st = WDT_LOCKED;
				end
			end
			WDT_OPEN: begin
				if (wr_idx) begin
					if (io_req.wdata == WDT_KEY_LOCK) begin
						d.st = WDT_LOCKED;
					end else begin
						d.idx = io_req.wdata;
					end
				end
			end
			default: begin
				// Illegal code falls back to closed
				d.st = WDT_LOCKED;
			end
		endcase

		// Register writes through the data location
		if (open && wr_dat) begin
			if (q.idx == WDT_IDX_BANK) begin
				d.bank = io_req.wdata;
			end else if (wdt_sel) begin
				unique case (q.idx)
					WDT_IDX_ACT: d.act = io_req.wdata;
					WDT_IDX_UNIT: d.unit = io_req.wdata;
					WDT_IDX_CTL: begin
						d.kbd_en = io_req.wdata[WDT_CTL_KBD_BIT];
						d.ms_en = io_req.wdata[WDT_CTL_MS_BIT];
					end
					default: begin
						// Count handled below, others ignored
					end
				endcase
			end
		end

		// Counter: write reload, activity reload, or step
		if (cnt_wr) begin
			d.cnt = io_req.wdata;
			d.reload = io_req.wdata;
			d.sts = 1'b0;
		end else if (run && ((kbd_ev && q.kbd_en) || (ms_ev && q.ms_en))) begin
			d.cnt = q.reload;
		end else if (run && unit_tick) begin
			d.cnt = q.cnt - 8'h01;
			if (q.cnt == 8'h01) begin
				// Expiry sets status, which then holds
				d.sts = 1'b1;
				d.tmo = 1'b1;
			end
		end

		// Forced timeout; the bit itself is never stored
		if (open && wr_dat && wdt_sel && q.idx == WDT_IDX_CTL
				&& io_req.wdata[WDT_CTL_FORCE_BIT]) begin
			d.sts = 1'b1;
			d.tmo = 1'b1;
		end

		// Read data, answered the cycle after the strobe
		if (rd_idx) begin
			d.rdata = open ? q.idx : WDT_IDLE_READ;
		end else if (rd_dat) begin
			d.rdata = WDT_IDLE_READ;
			if (open && q.idx == WDT_IDX_BANK) begin
				d.rdata = q.bank;
			end else if (open && wdt_sel) begin
				unique case (q.idx)
					WDT_IDX_ACT: d.rdata = q.act;
					WDT_IDX_UNIT: d.rdata = q.unit;
					WDT_IDX_CNT: d.rdata = q.cnt;
					WDT_IDX_CTL: begin
						d.rdata = 8'h00;
						d.rdata[WDT_CTL_MS_BIT] = q.ms_en;
						d.rdata[WDT_CTL_KBD_BIT] = q.kbd_en;
						d.rdata[WDT_CTL_STS_BIT] = q.sts;
					end
					default: d.rdata = WDT_IDLE_READ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			q <= '0;
			q.st <= WDT_LOCKED;
			q.idx <= WDT_RST_IDX;
			q.bank <= WDT_RST_BANK;
			q.act <= WDT_RST_ACT;
			q.unit <= WDT_RST_UNIT;
			q.cnt <= WDT_RST_CNT;
			q.reload <= WDT_RST_CNT;
			q.rdata <= WDT_IDLE_READ;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, straight from flip-flops
	// ----------------------------------------------------------------
	assign io_rdata = q.rdata;
	assign timeout_pulse = q.tmo;
	assign timeout_sts = q.sts;

endmodule : wdt_top
